// file: verilog/lbp_pkg.sv
// Package: constants shared by the LED bank and pump control block
package lbp_pkg;
   // Sizes
   localparam int LBP_LV_SINKS = 5;
   localparam int LBP_HV_SINKS = 2;
   localparam int LBP_LV_BANKS = 4;
   localparam int LBP_PATTERNS = 4;
   localparam int LBP_ZONES = 5;
   localparam int LBP_MAPPERS = 3;
   // Field positions of the anode-connect word
   localparam int LBP_ANODE_HV_LSB = 0;
   localparam int LBP_ANODE_LV_LSB = 2;
   // Reset values
   localparam logic [6:0] LBP_ANODE_RST = 7'h7F;
   localparam logic [1:0] LBP_HVMAP_RST = 2'h0;
   localparam logic [7:0] LBP_BRIGHT_RST = 8'h00;
   localparam logic [4:0] LBP_FS_RST = 5'h13;
   localparam logic [1:0] LBP_PUMP_MODE_RST = 2'h0;
   // Timing: pump switching clock and duty measurement window
   localparam int LBP_MCLK_HZ = 25000000;
   localparam int LBP_PUMP_HZ = 1000000;
   localparam int LBP_PUMP_HALF = LBP_MCLK_HZ / LBP_PUMP_HZ / 2;
   localparam int LBP_DUTY_WIN = 255;
   localparam int LBP_CAP_CHECK_CYC = 16;
   // Pump mode encodings
   localparam logic [1:0] LBP_MODE_OFF = 2'h0;
   localparam logic [1:0] LBP_MODE_AUTO = 2'h1;
   localparam logic [1:0] LBP_MODE_1X = 2'h2;
   localparam logic [1:0] LBP_MODE_2X = 2'h3;
   // Brightness source select per bank: bit0 register, bit1 mapper, bit2 duty
   localparam int LBP_SRC_REG = 0;
   localparam int LBP_SRC_ALS = 1;
   localparam int LBP_SRC_DUTY = 2;
endpackage

// file: verilog/lbp_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module lbp_sync
   import lbp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic out_ff;
   wire agree = (s2_ff == s3_ff);

   // Only the second stage reads the first; output moves when stages 2 and 3 agree
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         out_ff <= 1'b0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (agree) begin
            out_ff <= s3_ff;
         end
      end
   end
   assign sync_out = out_ff;
endmodule

// file: verilog/lbp_pump_ctrl.sv
// Charge pump gain state machine and pump switching clock
`timescale 1ns/1ns
module lbp_pump_ctrl
   import lbp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic [1:0] pump_mode,
   input wire logic thermal_off,
   input wire logic headroom_low,
   input wire logic flying_capacitor_present,
   // Status
   output logic pump_path_on,
   output logic pump_gain_2x,
   output logic pump_clk
);
   typedef enum logic [2:0] {
      LBP_ST_OFF, LBP_ST_CHECK, LBP_ST_AUTO1X, LBP_ST_AUTO2X, LBP_ST_NOCAP, LBP_ST_F1X, LBP_ST_F2X
   } lbp_pump_e;
   lbp_pump_e state_ff;
   lbp_pump_e nxt_state;
   logic [1:0] mode_ff;
   logic [4:0] chk_ff;
   logic [4:0] div_ff;
   logic pclk_ff;
   logic [4:0] nxt_chk;
   wire mode_changed = (mode_ff != pump_mode);
   wire chk_done = (chk_ff == 5'(LBP_CAP_CHECK_CYC - 1));
   wire switching = (state_ff == LBP_ST_AUTO2X) || (state_ff == LBP_ST_F2X);
   wire div_wrap = (div_ff == 5'(LBP_PUMP_HALF - 1));

   // Gain selection; a mode change or disable restarts from the top
   always_comb begin
      nxt_state = state_ff;
      nxt_chk = 5'h00;
      if (thermal_off || mode_changed || pump_mode == LBP_MODE_OFF || state_ff == LBP_ST_OFF) begin
         nxt_state = LBP_ST_OFF;
         if (!thermal_off) begin
            case (pump_mode)
               LBP_MODE_AUTO: nxt_state = LBP_ST_CHECK;
               LBP_MODE_1X: nxt_state = LBP_ST_F1X;
               LBP_MODE_2X: nxt_state = LBP_ST_F2X;
               default: nxt_state = LBP_ST_OFF;
            endcase
         end
      end else begin
         case (state_ff)
            LBP_ST_OFF: nxt_state = LBP_ST_OFF;
            // Sample the capacitor sense for a settled window before trusting it
            LBP_ST_CHECK: begin
               nxt_chk = chk_ff + 5'h01;
               if (chk_done) begin
                  nxt_state = flying_capacitor_present ? LBP_ST_AUTO1X : LBP_ST_NOCAP;
               end
            end
            LBP_ST_AUTO1X: begin
               if (headroom_low) begin
                  nxt_state = LBP_ST_AUTO2X;
               end
            end
            LBP_ST_AUTO2X: nxt_state = LBP_ST_AUTO2X;
            LBP_ST_NOCAP: nxt_state = LBP_ST_NOCAP;
            LBP_ST_F1X: nxt_state = LBP_ST_F1X;
            LBP_ST_F2X: nxt_state = LBP_ST_F2X;
            default: nxt_state = LBP_ST_OFF;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_ff <= LBP_ST_OFF;
         mode_ff <= LBP_PUMP_MODE_RST;
         chk_ff <= 5'h00;
      end else begin
         state_ff <= nxt_state;
         mode_ff <= pump_mode;
         chk_ff <= nxt_chk;
      end
   end

   // Fixed-rate pump clock, toggling only while the pump switches
   always_ff @(posedge mclk) begin
      if (!rst_n || !switching) begin
         div_ff <= 5'h00;
         pclk_ff <= 1'b0;
      end else begin
         div_ff <= div_wrap ? 5'h00 : div_ff + 5'h01;
         if (div_wrap) begin
            pclk_ff <= ~pclk_ff;
         end
      end
   end

   assign pump_clk = pclk_ff;
   assign pump_gain_2x = switching;
   assign pump_path_on = (state_ff != LBP_ST_OFF) && (state_ff != LBP_ST_CHECK);
endmodule

// file: verilog/lbp_top.sv
// Top: LED bank mapping, brightness selection, protection and pump control
//
// Notes on behaviour
// - Four low-voltage banks; each of five low-voltage sinks maps to any bank.
// - Two-bit field assigns each high-voltage sink to bank A or B.
// - Each sink level is a 5-bit full scale with an 8-bit code.
// - High-voltage bank code comes from its register or its mapper, optionally scaled by duty.
// - Low-voltage bank code from register, duty, mapper or a combination.
// - Banks with duty input assigned are scaled by the measured duty cycle.
// - Ambient level maps to five zones; three mappers give target codes.
// - Four pattern generators with rise, fall, delay, levels and durations.
// - Enable pin low holds shutdown and every register at default.
// - Over-temperature disables boost, pump, sinks until indication clears.
// - High-voltage anode bits include the sink in boost feedback when set.
// - High-voltage anode bits select the shorted-string fault condition.
// - One bit selects boost frequency between two rates.
// - Pump switches from a fixed 1MHz clock when active.
// - Pump modes: disabled, automatic, forced 1X, forced 2X.
// - Disabled pump opens its path; low-voltage sinks keep running.
// - Automatic mode starts 1X, moves to 2X on active sink low headroom.
// - After automatic switch to 2X the pump stays there.
// - Automatic start checks flying capacitor; absent means 1X operation.
// - Forced 1X never switches.
// - Low-voltage anode bits let the sink steer pump gain when set.
// - Low-voltage anode bits select the shorted-string fault condition.
`timescale 1ns/1ns
module lbp_top
   import lbp_pkg::*;
(
   // Clock and enable pin used as reset
   input wire logic mclk,
   input wire logic rst_n,
   // Configuration
   input wire logic [1:0] hv_bank_map,
   input wire logic [9:0] lv_bank_map,
   input wire logic [4:0] lv_sink_en,
   input wire logic [1:0] hv_sink_en,
   input wire logic [6:0] anode_connect,
   input wire logic boost_freq_sel,
   input wire logic [1:0] pump_mode,
   input wire logic [29:0] bank_full_scale,
   input wire logic [47:0] bank_bright_code,
   input wire logic [17:0] bank_src_sel,
   input wire logic [11:0] bank_mapper_sel,
   input wire logic [11:0] bank_pattern_sel,
   input wire logic [119:0] mapper_targets,
   input wire logic [31:0] pattern_high_code,
   input wire logic [31:0] pattern_low_code,
   input wire logic [31:0] pattern_high_time,
   input wire logic [31:0] pattern_low_time,
   input wire logic [31:0] pattern_delay,
   input wire logic [31:0] pattern_ramp,
   input wire logic [3:0] pattern_en,
   // Ambient zone boundaries, upward and downward, and the ambient level
   input wire logic [31:0] zone_up_bound,
   input wire logic [31:0] zone_down_bound,
   input wire logic [7:0] ambient_light_input,
   // Pins and analog status
   input wire logic duty_input,
   input wire logic over_temp_140,
   input wire logic below_temp_125,
   input wire logic [4:0] lv_headroom_low,
   input wire logic [4:0] lv_sink_short,
   input wire logic [1:0] hv_sink_short,
   input wire logic flying_capacitor_present,
   // Sink drive
   output logic [39:0] lv_sink_code,
   output logic [24:0] lv_sink_fs,
   output logic [15:0] hv_sink_code,
   output logic [9:0] hv_sink_fs,
   output logic [4:0] lv_sink_on,
   output logic [1:0] hv_sink_on,
   // Boost and pump
   output logic boost_on,
   output logic boost_freq_1mhz,
   output logic [1:0] boost_fb_en,
   output logic pump_path_on,
   output logic pump_gain_2x,
   output logic pump_clk,
   // Status
   output logic [2:0] ambient_zone,
   output logic thermal_shutdown,
   output logic [4:0] lv_short_flag,
   output logic [1:0] hv_short_flag
);
   // Six banks: 0=A,1=B,2..5=C..F
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] scale8(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = a * b;
      scale8 = p[15:8] + {7'h00, p[7]};
   endfunction

   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   logic duty_s;
   logic hot_s;
   logic cool_s;
   lbp_sync u_sync_duty (.mclk(mclk), .rst_n(rst_n), .async_in(duty_input), .sync_out(duty_s));
   lbp_sync u_sync_hot (.mclk(mclk), .rst_n(rst_n), .async_in(over_temp_140), .sync_out(hot_s));
   lbp_sync u_sync_cool (.mclk(mclk), .rst_n(rst_n), .async_in(below_temp_125), .sync_out(cool_s));

   // ----------------------------------------
   // Thermal shutdown with hysteresis
   // ----------------------------------------
   logic therm_ff;
   // Two separate comparator flags give the hysteresis band
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         therm_ff <= 1'b0;
      end else if (hot_s) begin
         therm_ff <= 1'b1;
      end else if (cool_s) begin
         therm_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Duty cycle measurement
   // ----------------------------------------
   logic [7:0] win_ff;
   logic [7:0] hi_cnt_ff;
   logic [7:0] duty_ff;
   wire win_end = (win_ff == 8'(LBP_DUTY_WIN - 1));
   // Fixed window count; coarse but bounded latency, fine for a filtered input
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         win_ff <= 8'h00;
         hi_cnt_ff <= 8'h00;
         duty_ff <= 8'hFF;
      end else begin
         win_ff <= win_end ? 8'h00 : win_ff + 8'h01;
         if (win_end) begin
            duty_ff <= hi_cnt_ff + {7'h00, duty_s};
            hi_cnt_ff <= 8'h00;
         end else begin
            hi_cnt_ff <= hi_cnt_ff + {7'h00, duty_s};
         end
      end
   end

   // ----------------------------------------
   // Ambient zones with hysteresis
   // ----------------------------------------
   logic [2:0] zone_ff;
   wire [7:0] up_b = zone_up_bound[8*zone_ff[1:0] +: 8];
   wire [7:0] dn_b = zone_down_bound[8*2'(zone_ff - 3'h1) +: 8];
   wire zone_up = (zone_ff < 3'(LBP_ZONES - 1)) && (ambient_light_input > up_b);
   wire zone_dn = (zone_ff != 3'h0) && (ambient_light_input < dn_b);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         zone_ff <= 3'h0;
      end else if (zone_up) begin
         zone_ff <= zone_ff + 3'h1;
      end else if (zone_dn) begin
         zone_ff <= zone_ff - 3'h1;
      end
   end

   // ----------------------------------------
   // Pattern generators
   // ----------------------------------------
   logic [7:0] pat_cnt_ff [LBP_PATTERNS];
   logic [1:0] pat_ph_ff [LBP_PATTERNS];
   logic [7:0] pat_lvl_ff [LBP_PATTERNS];
   genvar g;
   generate
      for (g = 0; g < LBP_PATTERNS; g++) begin : g_pat
         wire [7:0] hi_c = pattern_high_code[8*g +: 8];
         wire [7:0] lo_c = pattern_low_code[8*g +: 8];
         wire [7:0] step = pattern_ramp[8*g +: 8] | 8'h01;
         wire [7:0] limit = (pat_ph_ff[g] == 2'h0) ? pattern_delay[8*g +: 8] :
                            (pat_ph_ff[g] == 2'h1) ? pattern_high_time[8*g +: 8] : pattern_low_time[8*g +: 8];
         wire done = (pat_cnt_ff[g] >= limit);
         wire [7:0] tgt = (pat_ph_ff[g] == 2'h1) ? hi_c : lo_c;
         wire [8:0] up_sum = {1'b0, pat_lvl_ff[g]} + {1'b0, step};
         wire [8:0] dn_dif = {1'b0, pat_lvl_ff[g]} - {1'b0, step};
         // Phases: delay, high, low; level ramps toward the phase target
         always_ff @(posedge mclk) begin
            if (!rst_n || !pattern_en[g]) begin
               pat_cnt_ff[g] <= 8'h00;
               pat_ph_ff[g] <= 2'h0;
               pat_lvl_ff[g] <= 8'h00;
            end else begin
               pat_cnt_ff[g] <= done ? 8'h00 : pat_cnt_ff[g] + 8'h01;
               if (done) begin
                  pat_ph_ff[g] <= (pat_ph_ff[g] == 2'h1) ? 2'h2 : 2'h1;
               end
               if (pat_lvl_ff[g] < tgt) begin
                  pat_lvl_ff[g] <= (up_sum[8] || up_sum[7:0] > tgt) ? tgt : up_sum[7:0];
               end else if (pat_lvl_ff[g] > tgt) begin
                  pat_lvl_ff[g] <= (dn_dif[8] || dn_dif[7:0] < tgt) ? tgt : dn_dif[7:0];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Per-bank brightness selection
   // ----------------------------------------
   logic [7:0] bank_code [6];
   generate
      for (g = 0; g < 6; g++) begin : g_bank
         wire [2:0] src = bank_src_sel[3*g +: 3];
         wire [1:0] msel = bank_mapper_sel[2*g +: 2];
         wire [1:0] midx = (msel > 2'h2) ? 2'h2 : msel;
         wire [7:0] als_c = mapper_targets[40*midx + 8*zone_ff +: 8];
         wire [7:0] reg_c = bank_bright_code[8*g +: 8];
         wire [7:0] pat_c = pat_lvl_ff[bank_pattern_sel[2*g +: 2]];
         wire pat_on = pattern_en[bank_pattern_sel[2*g +: 2]] && (g >= 2);
         // Mapper overrides register; high-voltage banks ignore patterns
         wire [7:0] base = src[LBP_SRC_ALS] ? als_c : (pat_on ? scale8(reg_c, pat_c) : reg_c);
         wire [7:0] base_ok = (src[LBP_SRC_ALS] || src[LBP_SRC_REG]) ? base : 8'hFF;
         assign bank_code[g] = src[LBP_SRC_DUTY] ? scale8(base_ok, duty_ff) : base_ok;
      end
   endgenerate

   // ----------------------------------------
   // Sink mapping and outputs
   // ----------------------------------------
   logic [39:0] lv_code_ff;
   logic [24:0] lv_fs_ff;
   logic [15:0] hv_code_ff;
   logic [9:0] hv_fs_ff;
   logic [4:0] lv_on_ff;
   logic [1:0] hv_on_ff;
   logic [4:0] lv_short_ff;
   logic [1:0] hv_short_ff;
   logic [4:0] lv_act;
   logic [39:0] nxt_lv_code;
   logic [24:0] nxt_lv_fs;
   logic [15:0] nxt_hv_code;
   logic [9:0] nxt_hv_fs;
   integer i;
   always_comb begin
      nxt_lv_code = 40'h0;
      nxt_lv_fs = 25'h0;
      nxt_hv_code = 16'h0;
      nxt_hv_fs = 10'h0;
      for (i = 0; i < LBP_LV_SINKS; i++) begin
         nxt_lv_code[8*i +: 8] = bank_code[2 + lv_bank_map[2*i +: 2]];
         nxt_lv_fs[5*i +: 5] = bank_full_scale[5*(2 + lv_bank_map[2*i +: 2]) +: 5];
      end
      for (i = 0; i < LBP_HV_SINKS; i++) begin
         nxt_hv_code[8*i +: 8] = bank_code[hv_bank_map[i]];
         nxt_hv_fs[5*i +: 5] = bank_full_scale[5*hv_bank_map[i] +: 5];
      end
   end
   wire [4:0] lv_anode = anode_connect[LBP_ANODE_LV_LSB +: LBP_LV_SINKS];
   wire [1:0] hv_anode = anode_connect[LBP_ANODE_HV_LSB +: LBP_HV_SINKS];
   assign lv_act = lv_sink_en & lv_anode & lv_headroom_low;
   wire headroom_low = |lv_act;

   // Registered drive; shutdown forces sinks off here, boost off below, and the pump off through thermal_off
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lv_code_ff <= 40'h0;
         lv_fs_ff <= {LBP_LV_SINKS{LBP_FS_RST}};
         hv_code_ff <= 16'h0;
         hv_fs_ff <= {LBP_HV_SINKS{LBP_FS_RST}};
         lv_on_ff <= 5'h00;
         hv_on_ff <= 2'h0;
         lv_short_ff <= 5'h00;
         hv_short_ff <= 2'h0;
      end else begin
         lv_code_ff <= nxt_lv_code;
         lv_fs_ff <= nxt_lv_fs;
         hv_code_ff <= nxt_hv_code;
         hv_fs_ff <= nxt_hv_fs;
         lv_on_ff <= therm_ff ? 5'h00 : lv_sink_en;
         hv_on_ff <= therm_ff ? 2'h0 : hv_sink_en;
         lv_short_ff <= lv_sink_short & lv_sink_en & lv_anode;
         hv_short_ff <= hv_sink_short & hv_sink_en & hv_anode;
      end
   end

   logic boost_on_ff;
   logic freq_ff;
   logic [1:0] fb_ff;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         boost_on_ff <= 1'b0;
         freq_ff <= 1'b0;
         fb_ff <= 2'h0;
      end else begin
         boost_on_ff <= !therm_ff && |hv_sink_en;
         freq_ff <= boost_freq_sel;
         fb_ff <= hv_anode & hv_sink_en;
      end
   end

   // ----------------------------------------
   // Charge pump
   // ----------------------------------------
   logic p_on;
   logic p_2x;
   logic p_clk;
   lbp_pump_ctrl u_pump (
      .mclk(mclk),
      .rst_n(rst_n),
      .pump_mode(pump_mode),
      .thermal_off(therm_ff),
      .headroom_low(headroom_low),
      .flying_capacitor_present(flying_capacitor_present),
      .pump_path_on(p_on),
      .pump_gain_2x(p_2x),
      .pump_clk(p_clk)
   );
   logic p_on_ff;
   logic p_2x_ff;
   logic p_clk_ff;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         p_on_ff <= 1'b0;
         p_2x_ff <= 1'b0;
         p_clk_ff <= 1'b0;
      end else begin
         p_on_ff <= p_on;
         p_2x_ff <= p_2x;
         p_clk_ff <= p_clk;
      end
   end

   assign lv_sink_code = lv_code_ff;
   assign lv_sink_fs = lv_fs_ff;
   assign hv_sink_code = hv_code_ff;
   assign hv_sink_fs = hv_fs_ff;
   assign lv_sink_on = lv_on_ff;
   assign hv_sink_on = hv_on_ff;
   assign boost_on = boost_on_ff;
   assign boost_freq_1mhz = freq_ff;
   assign boost_fb_en = fb_ff;
   assign pump_path_on = p_on_ff;
   assign pump_gain_2x = p_2x_ff;
   assign pump_clk = p_clk_ff;
   assign ambient_zone = zone_ff;
   assign thermal_shutdown = therm_ff;
   assign lv_short_flag = lv_short_ff;
   assign hv_short_flag = hv_short_ff;
endmodule

// file: verif/lbp_top_properties.sv
// Checker: port timing relations of the LED bank and pump control top
`timescale 1ns/1ns
module lbp_top_properties
   import lbp_pkg::*;
(
   // Clock and enable pin
   input wire logic mclk,
   input wire logic rst_n,
   // Inputs watched
   input wire logic [1:0] pump_mode,
   input wire logic [6:0] anode_connect,
   input wire logic [4:0] lv_sink_en,
   input wire logic [4:0] lv_headroom_low,
   input wire logic flying_capacitor_present,
   // Outputs watched
   input wire logic [4:0] lv_sink_on,
   input wire logic [24:0] lv_sink_fs,
   input wire logic [1:0] hv_sink_on,
   input wire logic boost_on,
   input wire logic pump_path_on,
   input wire logic pump_gain_2x,
   input wire logic pump_clk,
   input wire logic thermal_shutdown,
   input wire logic [4:0] lv_short_flag
);
   // ----------------------------------------
   // Sequences and assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Auto mode held three cycles covers the two-cycle lag of the pump outputs
   sequence s_auto_steady;
      (pump_mode == LBP_MODE_AUTO && !thermal_shutdown) [*3];
   endsequence
   sequence s_headroom_ask;
      pump_path_on && flying_capacitor_present && (lv_headroom_low & lv_sink_en & anode_connect[6:2]) != 5'h00;
   endsequence
   a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=>
      lv_sink_on == 5'h00 && !pump_path_on && lv_sink_fs == {5{LBP_FS_RST}}) else $error("reset value wrong");
   a_thermal_all_off: assert property (thermal_shutdown [*3] |->
      !boost_on && lv_sink_on == 5'h00 && hv_sink_on == 2'h0 && !pump_path_on) else $error("sink on while hot");
   a_lv_short_masked: assert property ((anode_connect[6:2] == 5'h00) [*2] |-> lv_short_flag == 5'h00)
      else $error("short flag not masked");
   a_pump_off_path: assert property ((pump_mode == LBP_MODE_OFF) [*4] |-> !pump_path_on && !pump_gain_2x)
      else $error("pump active when off");
   a_forced_1x_pass: assert property ((pump_mode == LBP_MODE_1X && !thermal_shutdown) [*5] |->
      pump_path_on && !pump_gain_2x) else $error("forced 1x wrong");
   a_pump_clk_half: assert property ($rose(pump_clk) && pump_mode == LBP_MODE_2X |->
      ##[10:14] ($fell(pump_clk) || pump_mode != LBP_MODE_2X)) else $error("pump clock half period");
   a_auto_sticky_2x: assert property (s_auto_steady ##0 pump_gain_2x |=> pump_gain_2x)
      else $error("auto 2x dropped");
   a_auto_switch_up: assert property (s_auto_steady ##0 s_headroom_ask |-> ##[1:4] pump_gain_2x)
      else $error("auto 2x not reached");
endmodule

bind lbp_top lbp_top_properties u_props (.*);

// file: verif/lbp_env_model.sv
// Far-side model: die temperature comparators and duty-cycle pin source
`timescale 1ns/1ns
module lbp_env_model (
   // Clock
   input wire logic mclk,
   // Bench controls
   input wire logic [7:0] temp_c,
   input wire logic [7:0] duty_high,
   // Pins seen by the device
   output logic over_temp_140,
   output logic below_temp_125,
   output logic duty_input
);
   logic [7:0] duty_cnt_ff = 8'h00;
   // Two thresholds; the gap between them is what gives the hysteresis
   assign over_temp_140 = temp_c >= 8'd140;
   assign below_temp_125 = temp_c <= 8'd125;
   // Square wave of 255-cycle period, updated just after the edge like a real pin
   always @(posedge mclk) begin
      duty_cnt_ff <= (duty_cnt_ff == 8'hFE) ? 8'h00 : duty_cnt_ff + 8'h01;
   end
   assign duty_input = duty_cnt_ff < duty_high;
endmodule

// file: verif/lbp_top_tb_top.sv
// Testbench: directed sequences for the LED bank and pump control top
`timescale 1ns/1ns
module lbp_top_tb_top;
   import lbp_pkg::*;
   // ----------------------------------------
   // Signals, design and far side
   // ----------------------------------------
   logic mclk = 1'b0;
   logic rst_n;
   logic [1:0] hv_bank_map, hv_sink_en, pump_mode, hv_sink_short, hv_sink_on, boost_fb_en, hv_short_flag;
   logic [7:0] ambient_light_input, temp_c;
   logic [4:0] lv_sink_en, lv_headroom_low, lv_sink_short, lv_sink_on, lv_short_flag;
   logic [6:0] anode_connect;
   logic boost_freq_sel, flying_capacitor_present, duty_input, over_temp_140, below_temp_125;
   logic boost_on, boost_freq_1mhz, pump_path_on, pump_gain_2x, pump_clk, thermal_shutdown;
   logic [29:0] bank_full_scale;
   logic [47:0] bank_bright_code;
   logic [17:0] bank_src_sel;
   logic [11:0] bank_mapper_sel, bank_pattern_sel;
   logic [119:0] mapper_targets;
   logic [31:0] zone_up_bound, zone_down_bound, pat_word;
   logic [3:0] pattern_en;
   logic [39:0] lv_sink_code;
   logic [24:0] lv_sink_fs;
   logic [15:0] hv_sink_code;
   logic [9:0] hv_sink_fs, lv_bank_map;
   logic [2:0] ambient_zone;
   int err_total = 0;
   int compares = 0;
   // Pattern words share one driven value
   lbp_top uut (.*, .pattern_high_code(pat_word), .pattern_low_code(pat_word), .pattern_high_time(pat_word),
      .pattern_low_time(pat_word), .pattern_delay(pat_word), .pattern_ramp(pat_word));
   lbp_env_model env (.mclk, .temp_c, .duty_high(8'h80), .over_temp_140, .below_temp_125, .duty_input);
   always #20 mclk = ~mclk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog: the sequence needs about 950 cycles
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   // Main sequence; inputs change only at falling edges
   initial begin
      int m;
      int n;
      logic prev;
      rst_n = 1'b0;
      {hv_bank_map, hv_sink_en, hv_sink_short, lv_bank_map} = {2'h2, 2'h3, 2'h0, 10'h1B};
      {pump_mode, ambient_light_input, temp_c} = {LBP_MODE_OFF, 8'h00, 8'd25};
      {lv_sink_en, lv_headroom_low, lv_sink_short} = {5'h1F, 5'h00, 5'h00};
      {anode_connect, boost_freq_sel, flying_capacitor_present} = {LBP_ANODE_RST, 1'b0, 1'b1};
      bank_full_scale = {5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
      bank_bright_code = 48'h665544332211;
      {bank_src_sel, bank_mapper_sel, bank_pattern_sel} = {18'h09249, 12'h000, 12'h000};
      mapper_targets = {40'hE5E4E3E2E1, 80'h0};
      {zone_up_bound, zone_down_bound} = {32'hC0804020, 32'hB8783818};
      {pat_word, pattern_en} = {32'h00000000, 4'h0};
      cyc(16);
      chk(lv_sink_fs, {5{LBP_FS_RST}});
      chk(pump_path_on, 1'b0);
      rst_n = 1'b1;
      cyc(4);
      for (int i = 0; i < 5; i++) begin
         m = 2 + lv_bank_map[2*i +: 2];
         chk(lv_sink_code[8*i +: 8], bank_bright_code[8*m +: 8]);
         chk(lv_sink_fs[5*i +: 5], bank_full_scale[5*m +: 5]);
      end
      chk(hv_sink_code, 16'h2211);
      chk(hv_sink_fs, 10'h041);
      chk(lv_sink_on, 5'h1F);
      $display("test bank mapping done");
      bank_src_sel[5:3] = 3'b010;
      bank_mapper_sel[3:2] = 2'h2;
      cyc(4);
      chk(hv_sink_code[15:8], 8'hE1);
      ambient_light_input = 8'h50;
      cyc(10);
      chk(ambient_zone, 3'h2);
      chk(hv_sink_code[15:8], 8'hE3);
      $display("test ambient mapper done");
      {lv_sink_short, hv_sink_short} = {5'h15, 2'h3};
      cyc(4);
      chk({lv_short_flag, hv_short_flag, boost_fb_en}, {5'h15, 2'h3, 2'h3});
      anode_connect = 7'h00;
      cyc(4);
      chk({lv_short_flag, hv_short_flag, boost_fb_en}, 9'h000);
      anode_connect = LBP_ANODE_RST;
      for (int b = 0; b < 2; b++) begin
         boost_freq_sel = b[0];
         cyc(3);
         chk(boost_freq_1mhz, b[0]);
      end
      $display("test anode and boost done");
      // Fixed modes: off, forced 1X, forced 2X with switching-clock edges counted
      for (int k = 0; k < 4; k++) begin
         if (k != 1) begin
            pump_mode = k[1:0];
            cyc(6);
            chk({pump_path_on, pump_gain_2x}, {k != 0, k == 3});
            n = 0;
            prev = pump_clk;
            repeat (20 * LBP_PUMP_HALF) begin
               cyc(1);
               if (pump_clk === 1'b1 && prev === 1'b0) n++;
               prev = pump_clk;
            end
            chk(n, (k == 3) ? 10 : 0);
         end
      end
      $display("test fixed pump modes done");
      pump_mode = LBP_MODE_AUTO;
      anode_connect = 7'h7B;
      cyc(30);
      chk({pump_path_on, pump_gain_2x}, 2'b10);
      lv_headroom_low = 5'h01;
      cyc(6);
      chk(pump_gain_2x, 1'b0);
      anode_connect = LBP_ANODE_RST;
      cyc(6);
      chk(pump_gain_2x, 1'b1);
      lv_headroom_low = 5'h00;
      cyc(6);
      chk(pump_gain_2x, 1'b1);
      pump_mode = LBP_MODE_OFF;
      cyc(3);
      pump_mode = LBP_MODE_AUTO;
      cyc(30);
      chk(pump_gain_2x, 1'b0);
      pump_mode = LBP_MODE_OFF;
      flying_capacitor_present = 1'b0;
      cyc(3);
      pump_mode = LBP_MODE_AUTO;
      cyc(30);
      lv_headroom_low = 5'h01;
      cyc(6);
      chk({pump_path_on, pump_gain_2x}, 2'b10);
      $display("test automatic gain done");
      {bank_src_sel[2:0], pat_word, pattern_en} = {3'b101, 32'h40404040, 4'h1};
      cyc(4);
      chk({hv_sink_code[7:0], lv_sink_code[31:24]}, 16'h090D);
      $display("test duty and pattern done");
      temp_c = 8'd145;
      cyc(10);
      chk({thermal_shutdown, lv_sink_on, boost_on}, {1'b1, 5'h00, 1'b0});
      temp_c = 8'd130;
      cyc(10);
      chk(thermal_shutdown, 1'b1);
      temp_c = 8'd120;
      cyc(10);
      chk(thermal_shutdown, 1'b0);
      rst_n = 1'b0;
      cyc(2);
      chk(lv_sink_code, 40'h0);
      chk(lv_sink_fs, {5{LBP_FS_RST}});
      rst_n = 1'b1;
      $display("test thermal and reset done");
      cyc(4);
      conclude();
   end
endmodule
